/* File: hw/fsp_pkg.sv */
// constants and types for the flash status and protection block
package fsp_pkg;
  localparam int unsigned STAT_W = 8;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 16;
  // status byte bit positions
  localparam int unsigned BIT_READY = 7;
  localparam int unsigned BIT_ERASE_ERR = 5;
  localparam int unsigned BIT_PROG_ERR = 4;
  localparam int unsigned BIT_OVERPROG = 3;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  // command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h41;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
  localparam logic [7:0] CMD_LOCK_PROGRAM = 8'h77;
  localparam logic [7:0] CMD_ERASE_ALL = 8'ha7;
  localparam logic [7:0] CMD_READ_LOCK = 8'h71;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  // page load: 256 bytes as 128 16-bit words
  localparam int unsigned PAGE_WORDS = 128;
  localparam logic [6:0] PAGE_LAST = 7'h7f;
  // protect control byte and its fields
  localparam logic [23:0] PROTECT_ADDR = 24'h00ffff;
  localparam int unsigned PROT_L1_LO = 0;
  localparam int unsigned PROT_L2_LO = 2;
  localparam int unsigned PROT_REL_LO = 4;
  localparam logic [1:0] PROT_PAIR_OFF = 2'h3;
  localparam logic [1:0] PROT_REL_OFF = 2'h0;
  // identification code
  localparam int unsigned ID_BYTES = 7;
  localparam logic [23:0] ID_FIRST_ADDR = 24'h0fffdf;
  // boot area window, one erase block
  localparam logic [23:0] BOOT_LO = 24'h0fe000;
  localparam logic [23:0] BOOT_HI = 24'h0fffff;

  typedef enum logic [2:0] {
    FSP_OP_NONE = 3'h0,
    FSP_OP_PAGE = 3'h1,
    FSP_OP_BLOCK_ERASE = 3'h2,
    FSP_OP_LOCK_PROGRAM = 3'h3,
    FSP_OP_ERASE_ALL = 3'h4
  } fsp_op_t;

  typedef enum logic [1:0] {
    FSP_RD_ARRAY = 2'h0,
    FSP_RD_STATUS = 2'h1,
    FSP_RD_LOCK = 2'h2
  } fsp_rd_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fsp_cmd_t;

  typedef struct packed {
    logic done;
    logic fail;
    logic overprog;
  } fsp_result_t;
endpackage : fsp_pkg

/* File: hw/fsp_flash_status_and_protect.sv */
// command sequencing, status byte and protection for the flash array
// Notes on behaviour
// - failed automatic write sets program-error flag, status bit 4.
// - program-error flag persists until the status clear command runs.
// - erase setup followed by a code other than confirm or read-array sets both error flags.
// - while bit 5 or bit 4 is set, program and erase commands are refused.
// - invalid or malformed command sets both error flags.
// - second cycle of two-cycle commands other than confirm or read-array errs.
// - read-array in second cycle cancels the setup, no error.
// - over-programmed page write sets status bit 3.
// - page write yields 80, 90 or 88 status for ok, fail, over-program.
// - bit 7 ready, bits 5..3 error flags, others reserved.
// - parallel mode protection comes from the byte at 0FFFF.
// - any zero in an enable pair blocks readout and modification.
// - two levels; level 2 also blocks tester readout and wins.
// - release bits at 00 turn protection off.
// - active protection forbids changing release bits in parallel mode.
// - serial mode, non-blank flash: identification mismatch ignores commands.
// - identification code is 8-bit bytes starting at 0FFFDF.
// - the boot area is one 8 Kbyte erase block.
// - user and boot areas are programmed and erased alike.
// - status clear command 50 resets bits 5, 4 and 3.
// - reset leaves the status byte at 80.
// - ready reads 0 during automatic operations, 1 afterwards.
`timescale 1ns/1ns
`default_nettype none
module fsp_flash_status_and_protect (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire fsp_pkg::fsp_cmd_t i_cmd,
  input wire fsp_pkg::fsp_result_t i_result,
  input wire logic i_parallel_mode,
  input wire logic i_serial_mode,
  input wire logic [7:0] i_protect_byte,
  input wire logic i_protect_wr_req,
  input wire logic [7:0] i_protect_wr_data,
  input wire logic i_id_check,
  input wire logic [8*fsp_pkg::ID_BYTES-1:0] i_id_received,
  input wire logic [8*fsp_pkg::ID_BYTES-1:0] i_id_stored,
  output logic [7:0] o_status_byte,
  output logic o_ready_not_busy,
  output fsp_pkg::fsp_rd_t o_read_mode,
  output logic o_op_start,
  output fsp_pkg::fsp_op_t o_op_kind,
  output logic [fsp_pkg::ADDR_W-1:0] o_op_addr,
  output logic o_page_data_we,
  output logic [6:0] o_page_index,
  output logic [fsp_pkg::DATA_W-1:0] o_page_data,
  output logic o_cmd_refused,
  output logic o_read_blocked,
  output logic o_modify_blocked,
  output logic o_tester_read_blocked,
  output logic o_protect_wr_allow,
  output logic o_id_accept,
  output logic o_addr_in_boot
);
  typedef enum logic [1:0] {
    FSP_ST_IDLE = 2'h0,
    FSP_ST_CONFIRM = 2'h1,
    FSP_ST_LOAD = 2'h2,
    FSP_ST_BUSY = 2'h3
  } fsp_state_t;

  function automatic logic fsp_in_boot(input logic [23:0] a);
    fsp_in_boot = (a >= fsp_pkg::BOOT_LO) && (a <= fsp_pkg::BOOT_HI);
  endfunction : fsp_in_boot

  fsp_state_t state;
  fsp_state_t next_state;
  fsp_pkg::fsp_op_t pend_op;
  fsp_pkg::fsp_op_t next_pend_op;
  fsp_pkg::fsp_rd_t next_read_mode;
  logic [6:0] load_cnt;
  logic erase_err;
  logic prog_err;
  logic overprog;
  logic id_ok;

  wire logic [7:0] code = i_cmd.data[7:0];
  wire logic cmd_we = i_cmd.we && o_id_accept;
  wire logic any_err = erase_err || prog_err;
  wire logic is_setup_code = (code == fsp_pkg::CMD_BLOCK_ERASE) ||
      (code == fsp_pkg::CMD_LOCK_PROGRAM) || (code == fsp_pkg::CMD_ERASE_ALL);
  wire logic is_modify_code = is_setup_code ||
      (code == fsp_pkg::CMD_PAGE_PROGRAM);
  wire logic is_plain_code = (code == fsp_pkg::CMD_READ_ARRAY) ||
      (code == fsp_pkg::CMD_READ_STATUS) ||
      (code == fsp_pkg::CMD_CLEAR_STATUS) ||
      (code == fsp_pkg::CMD_READ_LOCK);
  wire logic idle_we = cmd_we && (state == FSP_ST_IDLE);
  wire logic conf_we = cmd_we && (state == FSP_ST_CONFIRM);
  wire logic refuse = idle_we && any_err && is_modify_code;
  wire logic bad_code = idle_we && !is_plain_code && !is_modify_code;
  // second cycle neither confirm nor read array
  wire logic bad_conf = conf_we && (code != fsp_pkg::CMD_CONFIRM) &&
      (code != fsp_pkg::CMD_READ_ARRAY);
  wire logic seq_err = bad_code || bad_conf;
  wire logic clear_cmd = idle_we && (code == fsp_pkg::CMD_CLEAR_STATUS);
  wire logic confirmed = conf_we && (code == fsp_pkg::CMD_CONFIRM);
  wire logic load_done = cmd_we && (state == FSP_ST_LOAD) &&
      (load_cnt == fsp_pkg::PAGE_LAST);
  wire logic op_end = (state == FSP_ST_BUSY) && i_result.done;
  wire logic erase_op = (pend_op != fsp_pkg::FSP_OP_PAGE);

  // protection decode
  wire logic [1:0] prot_l1 = i_protect_byte[fsp_pkg::PROT_L1_LO +: 2];
  wire logic [1:0] prot_l2 = i_protect_byte[fsp_pkg::PROT_L2_LO +: 2];
  wire logic [1:0] prot_rel = i_protect_byte[fsp_pkg::PROT_REL_LO +: 2];
  wire logic prot_released = (prot_rel == fsp_pkg::PROT_REL_OFF);
  // any zero in a pair turns protection on
  wire logic l1_sel = (prot_l1 != fsp_pkg::PROT_PAIR_OFF);
  wire logic l2_sel = (prot_l2 != fsp_pkg::PROT_PAIR_OFF);
  wire logic prot_on = i_parallel_mode && !prot_released && (l1_sel || l2_sel);
  // level 2 wins when both chosen
  wire logic prot_l2_on = prot_on && l2_sel;
  wire logic rel_change = i_protect_wr_data[fsp_pkg::PROT_REL_LO +: 2] !=
      prot_rel;

  // blank when every stored byte is all ones
  wire logic id_blank = &i_id_stored;
  // compare received code with the stored bytes
  wire logic id_match = (i_id_received == i_id_stored);

  always_comb begin
    next_state = state;
    next_pend_op = pend_op;
    next_read_mode = o_read_mode;
    case (state)
      FSP_ST_IDLE: begin
        if (idle_we && !refuse) begin
          case (code)
            fsp_pkg::CMD_READ_ARRAY: next_read_mode = fsp_pkg::FSP_RD_ARRAY;
            fsp_pkg::CMD_READ_STATUS: next_read_mode = fsp_pkg::FSP_RD_STATUS;
            fsp_pkg::CMD_READ_LOCK: next_read_mode = fsp_pkg::FSP_RD_LOCK;
            fsp_pkg::CMD_PAGE_PROGRAM: begin
              next_pend_op = fsp_pkg::FSP_OP_PAGE;
              next_state = FSP_ST_LOAD;
            end
            fsp_pkg::CMD_BLOCK_ERASE: begin
              next_pend_op = fsp_pkg::FSP_OP_BLOCK_ERASE;
              next_state = FSP_ST_CONFIRM;
            end
            fsp_pkg::CMD_LOCK_PROGRAM: begin
              next_pend_op = fsp_pkg::FSP_OP_LOCK_PROGRAM;
              next_state = FSP_ST_CONFIRM;
            end
            fsp_pkg::CMD_ERASE_ALL: begin
              next_pend_op = fsp_pkg::FSP_OP_ERASE_ALL;
              next_state = FSP_ST_CONFIRM;
            end
            // bad codes and clear leave the read mode alone
            default: next_read_mode = o_read_mode;
          endcase
        end
      end
      FSP_ST_CONFIRM: begin
        if (confirmed) begin
          next_state = FSP_ST_BUSY;
          next_read_mode = fsp_pkg::FSP_RD_STATUS;
        end else if (conf_we) begin
          // cancel setup; read-array falls back to array read, a bad code to status read
          next_state = FSP_ST_IDLE;
          next_pend_op = fsp_pkg::FSP_OP_NONE;
          if (!bad_conf) begin
            next_read_mode = fsp_pkg::FSP_RD_ARRAY;
          end else begin
            next_read_mode = fsp_pkg::FSP_RD_STATUS;
          end
        end
      end
      FSP_ST_LOAD: begin
        if (load_done) begin
          next_state = FSP_ST_BUSY;
          next_read_mode = fsp_pkg::FSP_RD_STATUS;
        end
      end
      FSP_ST_BUSY: begin
        if (i_result.done) begin
          next_state = FSP_ST_IDLE;
          next_pend_op = fsp_pkg::FSP_OP_NONE;
        end
      end
      default: next_state = FSP_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= FSP_ST_IDLE;
      pend_op <= fsp_pkg::FSP_OP_NONE;
      o_read_mode <= fsp_pkg::FSP_RD_ARRAY;
    end else begin
      state <= next_state;
      pend_op <= next_pend_op;
      o_read_mode <= next_read_mode;
    end
  end

  // page words are counted; the address is latched at the setup write and retaken at the second cycle of an erase or lock setup
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      load_cnt <= 7'h00;
      o_op_addr <= '0;
    end else if (idle_we && !refuse) begin
      load_cnt <= 7'h00;
      o_op_addr <= i_cmd.addr;
    end else if (conf_we) begin
      // boot erase snaps to the one boot block
      o_op_addr <= fsp_in_boot(i_cmd.addr) ? fsp_pkg::BOOT_LO : i_cmd.addr;
    end else if (cmd_we && state == FSP_ST_LOAD) begin
      load_cnt <= load_cnt + 7'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_page_data_we <= 1'b0;
      o_page_index <= 7'h00;
      o_page_data <= '0;
      o_op_start <= 1'b0;
      o_op_kind <= fsp_pkg::FSP_OP_NONE;
      o_cmd_refused <= 1'b0;
    end else begin
      o_page_data_we <= cmd_we && (state == FSP_ST_LOAD);
      o_page_index <= load_cnt;
      o_page_data <= i_cmd.data;
      o_op_start <= confirmed || load_done;
      if (confirmed || load_done) begin
        o_op_kind <= pend_op;
      end
      o_cmd_refused <= refuse || (i_cmd.we && !o_id_accept);
    end
  end

  // status clear; a set in the clear cycle wins
  wire logic next_prog_err = seq_err || (op_end && i_result.fail) ||
      (prog_err && !clear_cmd);
  wire logic next_erase_err = seq_err ||
      (op_end && erase_op && i_result.fail) || (erase_err && !clear_cmd);
  wire logic next_overprog = (op_end && !erase_op && i_result.overprog) ||
      (overprog && !clear_cmd);

  logic [7:0] next_status;
  always_comb begin
    next_status = 8'h00;
    next_status[fsp_pkg::BIT_READY] = (next_state != FSP_ST_BUSY);
    next_status[fsp_pkg::BIT_ERASE_ERR] = next_erase_err;
    next_status[fsp_pkg::BIT_PROG_ERR] = next_prog_err;
    next_status[fsp_pkg::BIT_OVERPROG] = next_overprog;
  end

  // status byte loads next values so it moves with the flags and state
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      erase_err <= 1'b0;
      prog_err <= 1'b0;
      overprog <= 1'b0;
      o_status_byte <= fsp_pkg::STATUS_RESET;
    end else begin
      erase_err <= next_erase_err;
      prog_err <= next_prog_err;
      overprog <= next_overprog;
      o_status_byte <= next_status;
    end
  end

  assign o_ready_not_busy = (state != FSP_ST_BUSY);

  // identification result held until the next check; mode exit clears it
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      id_ok <= 1'b0;
    end else if (!i_serial_mode) begin
      id_ok <= 1'b0;
    end else if (i_id_check) begin
      id_ok <= id_blank || id_match;
    end
  end

  // commands ignored in serial mode until accepted
  assign o_id_accept = !i_serial_mode || id_ok;

  assign o_read_blocked = prot_on;
  assign o_modify_blocked = prot_on;
  assign o_tester_read_blocked = prot_l2_on;
  // release bits frozen while protected in parallel mode
  assign o_protect_wr_allow = i_protect_wr_req &&
      !(prot_on && rel_change);
  // boot window indicator for the current command address
  assign o_addr_in_boot = fsp_in_boot(i_cmd.addr);
endmodule : fsp_flash_status_and_protect
`default_nettype wire

/* File: dv/fsp_seq_model.sv */
// write sequencer stand-in: answers each op start with a done pulse
`timescale 1ns/1ns
`default_nettype none
module fsp_seq_model (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_op_start,
  input wire logic [1:0] i_outcome,
  input wire logic [3:0] i_delay,
  output fsp_pkg::fsp_result_t o_result
);
  logic busy;
  logic junk;
  logic [3:0] cnt;
  wire fire = busy && cnt == 4'h0;
  // flags are junk outside done so a design that samples early is caught
  assign o_result = '{done: fire, fail: fire ? i_outcome[0] : junk,
                      overprog: fire ? i_outcome[1] : ~junk};
  always_ff @(posedge i_clk) begin
    junk <= i_srst ? 1'b0 : ~junk;
    if (i_srst) begin
      busy <= 1'b0;
      cnt <= 4'h0;
    end else if (i_op_start) begin
      busy <= 1'b1;
      cnt <= i_delay;
    end else if (fire) begin
      busy <= 1'b0;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule : fsp_seq_model
`default_nettype wire

/* File: dv/fsp_flash_status_and_protect_asserts.sv */
// port checks for the flash status and protection block
`timescale 1ns/1ns
`default_nettype none
module fsp_flash_status_and_protect_asserts (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire fsp_pkg::fsp_cmd_t i_cmd,
  input wire fsp_pkg::fsp_result_t i_result,
  input wire logic i_parallel_mode,
  input wire logic i_serial_mode,
  input wire logic [7:0] i_protect_byte,
  input wire logic [7:0] o_status_byte,
  input wire logic o_ready_not_busy,
  input wire logic o_op_start,
  input wire logic o_cmd_refused,
  input wire logic o_read_blocked,
  input wire logic o_modify_blocked,
  input wire logic o_tester_read_blocked
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire on = i_parallel_mode && i_protect_byte[5:4] != 2'h0;
  chk_reserved_zero: assert property (
    {o_status_byte[6], o_status_byte[2:0]} == 4'h0) else $error("reserved");
  chk_ready_mirror: assert property (
    o_status_byte[7] == o_ready_not_busy) else $error("ready mismatch");
  chk_reset_value: assert property (
    $past(i_srst) |-> o_status_byte == 8'h80) else $error("reset status");
  chk_start_busy: assert property (
    o_op_start |-> !o_ready_not_busy ##1 !o_ready_not_busy)
    else $error("not busy at start");
  chk_ready_done: assert property (
    $rose(o_ready_not_busy) && !$past(i_srst) |-> $past(i_result.done))
    else $error("ready without done");
  chk_flag_persist: assert property (
    $fell(o_status_byte[4]) && !$past(i_srst) |->
    $past(i_cmd.we && i_cmd.data[7:0] == 8'h50)) else $error("flag lost");
  chk_refuse_cause: assert property (
    o_cmd_refused && !$past(i_serial_mode) |->
    $past(o_status_byte[5:4]) != 2'h0) else $error("bad refusal");
  chk_release_off: assert property (
    !on |-> !o_read_blocked && !o_modify_blocked) else $error("blocked");
  chk_level_two: assert property (
    on && i_protect_byte[3:2] != 2'h3 |->
    o_tester_read_blocked && o_read_blocked && o_modify_blocked)
    else $error("level two");
endmodule : fsp_flash_status_and_protect_asserts
bind fsp_flash_status_and_protect fsp_flash_status_and_protect_asserts
  u_chk (.i_clk, .i_srst, .i_cmd, .i_result, .i_parallel_mode,
  .i_serial_mode, .i_protect_byte, .o_status_byte, .o_ready_not_busy,
  .o_op_start, .o_cmd_refused, .o_read_blocked, .o_modify_blocked,
  .o_tester_read_blocked);
`default_nettype wire

/* File: dv/fsp_flash_status_and_protect_tb_top.sv */
// self-checking bench for the flash status and protection block
`timescale 1ns/1ns
`default_nettype none
module fsp_flash_status_and_protect_tb_top;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  fsp_pkg::fsp_cmd_t i_cmd = '0;
  fsp_pkg::fsp_result_t res;
  logic i_parallel_mode = 1'b0, i_serial_mode = 1'b0, i_id_check = 1'b0;
  logic i_protect_wr_req = 1'b0;
  logic [7:0] i_protect_byte = 8'hff, i_protect_wr_data = 8'h00;
  logic [55:0] i_id_received = '0, i_id_stored = '0;
  logic [7:0] o_status_byte;
  logic o_ready_not_busy, o_op_start, o_page_data_we, o_cmd_refused;
  logic o_read_blocked, o_modify_blocked, o_tester_read_blocked;
  logic o_protect_wr_allow, o_id_accept, o_addr_in_boot;
  fsp_pkg::fsp_rd_t o_read_mode;
  fsp_pkg::fsp_op_t o_op_kind;
  logic [23:0] o_op_addr;
  logic [6:0] o_page_index;
  logic [15:0] o_page_data, pd;
  logic [1:0] outcome = 2'h0;
  logic [3:0] delay = 4'h0;
  logic [2:0] e;
  int seed = 48;
  int n_mismatch = 0, samples_checked = 0;
  logic [15:0] codes [3] = '{16'h0020, 16'h0077, 16'h00a7};
  fsp_pkg::fsp_op_t kinds [3] = '{fsp_pkg::FSP_OP_BLOCK_ERASE,
    fsp_pkg::FSP_OP_LOCK_PROGRAM, fsp_pkg::FSP_OP_ERASE_ALL};
  logic [23:0] bnd [4] = '{24'h0fdfff, 24'h0fe000, 24'h0fffff, 24'h100000};
  always #10 i_clk = ~i_clk;
  fsp_flash_status_and_protect u_dut (.i_clk, .i_srst, .i_cmd,
    .i_result(res), .i_parallel_mode, .i_serial_mode, .i_protect_byte,
    .i_protect_wr_req, .i_protect_wr_data, .i_id_check, .i_id_received,
    .i_id_stored, .o_status_byte, .o_ready_not_busy, .o_read_mode,
    .o_op_start, .o_op_kind, .o_op_addr, .o_page_data_we, .o_page_index,
    .o_page_data, .o_cmd_refused, .o_read_blocked, .o_modify_blocked,
    .o_tester_read_blocked, .o_protect_wr_allow, .o_id_accept,
    .o_addr_in_boot);
  fsp_seq_model u_seq (.i_clk, .i_srst, .i_op_start(o_op_start),
    .i_outcome(outcome), .i_delay(delay), .o_result(res));
  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one write cycle; pulses of the taking edge are visible on return
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(negedge i_clk);
    i_cmd = '{we: 1'b1, addr: a, data: d};
    @(negedge i_clk);
    i_cmd.we = 1'b0;
  endtask : wr
  task automatic wait_rdy;
    for (int k = 0; k < 40 && o_ready_not_busy !== 1'b1; k++) @(negedge i_clk);
    chk(o_ready_not_busy, 1'b1);
  endtask : wait_rdy
  function automatic logic [7:0] exp_page(input logic [1:0] o);
    return 8'h80 | (o[0] ? 8'h10 : 8'h00) | (o[1] ? 8'h08 : 8'h00);
  endfunction : exp_page
  function automatic logic [2:0] exp_prot(input logic p, input logic [7:0] b);
    logic on;
    on = p && b[5:4] != 2'h0 && (b[1:0] != 2'h3 || b[3:2] != 2'h3);
    return {on && b[3:2] != 2'h3, on, on};
  endfunction : exp_prot
  initial begin
    // about ten times the expected run length
    #200000;
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (8) @(negedge i_clk);
    i_srst = 1'b0;
    chk(o_status_byte, 8'h80);
    for (int o = 0; o < 3; o++) begin
      outcome = o[1:0];
      delay = 4'($random(seed));
      wr(24'h000000, 16'h0041);
      for (int k = 0; k < 128; k++) begin
        pd = 16'($random(seed));
        wr({16'h0000, k[6:0], 1'b0}, pd);
        chk({o_page_data_we, o_page_index, o_page_data}, {1'b1, k[6:0], pd});
      end
      chk({o_op_start, o_ready_not_busy}, 2'h2);
      wait_rdy();
      wr(24'h0, 16'h0070);
      chk(o_status_byte, exp_page(o[1:0]));
      wr(24'h0, 16'h0050);
      chk(o_status_byte, 8'h80);
    end
    foreach (codes[i]) begin
      wr(24'h0fe123, codes[i]);
      wr(24'h0fe123, 16'h00ff);
      chk({o_status_byte, 6'h0, o_read_mode}, 16'h8000);
      wr(24'h0fe123, codes[i]);
      wr(24'h0fe123, 16'h00c3);
      chk(o_status_byte, 8'hb0);
      wr(24'h0, 16'h0041);
      chk({o_cmd_refused, o_status_byte}, 9'h1b0);
      wr(24'h0, 16'h0050);
      outcome = {1'b0, i != 1 && $random(seed) % 2 != 0};
      delay = 4'($random(seed));
      wr(24'h0fe123, codes[i]);
      wr(24'h0fe123, 16'h00d0);
      chk({o_op_start, o_op_kind}, {1'b1, kinds[i]});
      if (i == 0) chk(o_op_addr, 24'h0fe000);
      wait_rdy();
      chk(o_status_byte, outcome[0] ? 8'hb0 : 8'h80);
      wr(24'h0, 16'h0050);
    end
    wr(24'h0, 16'h0033);
    chk(o_status_byte, 8'hb0);
    wr(24'h0, 16'h0050);
    wr(24'h0, 16'h0071);
    chk({o_status_byte, o_read_mode}, {8'h80, fsp_pkg::FSP_RD_LOCK});
    for (int k = 0; k < 24; k++) begin
      @(negedge i_clk);
      {i_parallel_mode, i_protect_byte, i_protect_wr_req, i_protect_wr_data} =
        18'($random(seed));
      if (k < 2) {i_parallel_mode, i_protect_byte} = k ? 9'h10f : 9'h130;
      e = exp_prot(i_parallel_mode, i_protect_byte);
      #5;
      chk({o_tester_read_blocked, o_read_blocked, o_modify_blocked}, e);
      chk(o_protect_wr_allow, i_protect_wr_req && !(e[0] &&
        i_protect_wr_data[5:4] != i_protect_byte[5:4]));
    end
    @(negedge i_clk);
    i_serial_mode = 1'b1;
    wr(24'h0, 16'h0070);
    chk(o_cmd_refused, 1'b1);
    // mismatch, blank, mismatch, match: each check must overwrite the last
    for (int k = 0; k < 4; k++) begin
      @(negedge i_clk);
      i_id_stored = k == 1 ? '1 : 56'({$random(seed), $random(seed)});
      i_id_received = k == 3 ? i_id_stored : i_id_stored ^ 56'h1;
      i_id_check = 1'b1;
      @(negedge i_clk);
      i_id_check = 1'b0;
      chk(o_id_accept, k[0]);
    end
    wr(24'h0, 16'h0070);
    chk(o_cmd_refused, 1'b0);
    i_serial_mode = 1'b0;
    foreach (bnd[i]) begin
      @(negedge i_clk);
      i_cmd.addr = bnd[i];
      #5;
      chk(o_addr_in_boot, i == 1 || i == 2);
    end
    conclude();
  end
endmodule : fsp_flash_status_and_protect_tb_top
`default_nettype wire
